// >>> shared/dcc_pkg.sv
// Purpose: Constants for the dual comparator control block.
// Assumes: Eight-bit registers reached over a plain strobe port.
// Notes: Behaviour
// Behaviour
// - Two comparators fed from shared analog inputs
// - Three-bit field selects eight configurations
// - Results readable in top bits, read-only
// - Result high when positive exceeds negative
// - Per-comparator polarity bit inverts bit and pin
// - Reference drives positive inputs only mode 110
// - Switch bit picks negative pair in 110
// - Output modes route raw results to pins
// - Direction bits still gate result pin drivers
// - Direction register sets pin direction always
// - Analog pins read zero from port data unless mode 111 (off)
// - Flag set while results differ from capture
// - Control access captures results, ends mismatch
// - Reset restores control, comparators off
package dcc_pkg;
   // Register bus shape.
   localparam int ADDR_W = 3;
   localparam int DATA_W = 8;
   // Register indexes on the strobe port.
   localparam logic [2:0] CTRL_IDX = 3'h0;
   localparam logic [2:0] DIR_IDX = 3'h1;
   localparam logic [2:0] PORT_IDX = 3'h2;
   localparam logic [2:0] STAT_IDX = 3'h3;
   localparam logic [2:0] MASK_IDX = 3'h4;
   // Reset values.
   localparam logic [5:0] CFG_RST = 6'h07;
   localparam logic [7:0] DIR_RST = 8'hff;
   localparam logic [7:0] PORT_RST = 8'h00;
   localparam logic [0:0] STAT_RST = 1'h0;
   localparam logic [0:0] MASK_RST = 1'h0;
   // Control register field positions.
   localparam int RES2_BIT = 7;
   localparam int RES1_BIT = 6;
   localparam int INV2_BIT = 5;
   localparam int INV1_BIT = 4;
   localparam int CIS_BIT = 3;
   localparam int MODE_MSB = 2;
   // Configuration codes.
   localparam logic [2:0] MODE_OFF = 3'h7;
   localparam logic [2:0] MODE_MUX4 = 3'h6;
   localparam logic [2:0] MODE_OUT_BOTH = 3'h3;
   localparam logic [2:0] MODE_OUT_ONE = 3'h5;
   // Port pin roles.
   localparam int PIN_RES1 = 1;
   localparam int PIN_RES2 = 2;
   localparam logic [7:0] ANALOG_MASK = 8'h78;
   // Status bit of the change event.
   localparam int CHG_BIT = 0;

   // True when the given configuration routes a result to its pin.
   function automatic logic pin_routed(input logic [2:0] mode, input logic second);
      if (mode == MODE_OUT_BOTH) begin
         pin_routed = 1'b1;
      end else if (mode == MODE_OUT_ONE) begin
         pin_routed = second;
      end else begin
         pin_routed = 1'b0;
      end
   endfunction
endpackage

// >>> verilog/dcc_sync.sv
// Purpose: Two-stage synchroniser for the raw comparator results.
// Assumes: Inputs are asynchronous analog comparator outputs.
// Notes: Only the second stage is visible outside.
`timescale 1ns/1ps
module dcc_sync (
   // Clock and reset.
   input wire logic mclk,
   input wire logic rst,
   // Raw and settled results.
   input wire logic [1:0] raw,
   output logic [1:0] sync
);
   logic [1:0] meta_r; // First stage, read only by the second.
   logic [1:0] sync_r; // Second stage.

   // Both stages sample every edge; reset clears them.
   always_ff @(posedge mclk) begin
      if (rst) begin
         meta_r <= 2'h0;
         sync_r <= 2'h0;
      end else begin
         meta_r <= raw;
         sync_r <= meta_r;
      end
   end

   assign sync = sync_r;
endmodule

// >>> verilog/dcc_top.sv
// Purpose: Control, result and pin logic of a dual comparator unit.
// Assumes: Analog cores, reference ladder and pin pads sit outside.
// Notes: Result pins follow the raw comparators with no clocking.
`timescale 1ns/1ps
module dcc_top (
   // Clock and reset.
   input wire logic mclk,
   input wire logic rst,
   // Register strobe port.
   input wire logic [2:0] addr,
   input wire logic [7:0] wr_data,
   input wire logic wr_stb,
   input wire logic rd_stb,
   output logic [7:0] rd_data,
   // Raw comparator outputs, positive above negative gives one.
   input wire logic cmp1_raw,
   input wire logic cmp2_raw,
   // Analog configuration controls.
   output logic [2:0] comparator_config_field,
   output logic cmp_on,
   output logic ref_to_pos,
   output logic neg_pair_sel,
   // Port F pins.
   input wire logic [7:0] pin_in,
   output logic [7:0] pin_out,
   output logic [7:0] pin_oe,
   // Interrupt.
   output logic irq
);
   // Writable control bits: polarity, switch and mode.
   logic [5:0] cfg_r, cfg_nxt;
   // Port direction, one means input.
   logic [7:0] port_f_direction_reg_r, port_f_direction_reg_nxt;
   // Port output latch.
   logic [7:0] port_r, port_nxt;
   // Sticky change status and its mask.
   logic [0:0] stat_r, stat_nxt;
   logic [0:0] mask_r, mask_nxt;
   // Results last captured by software.
   logic [1:0] cap_r, cap_nxt;
   // Read data, valid the cycle after the strobe.
   logic [7:0] rd_r, rd_nxt;
   // Registered analog controls and interrupt, with their next values.
   logic cmp_on_r, cmp_on_nxt;
   logic ref_r, ref_nxt;
   logic negsel_r, negsel_nxt;
   logic irq_r, irq_nxt;
   // Pad drive enables, one means drive.
   logic [7:0] oe_r, oe_nxt;
   // Mode as it will stand after this edge.
   logic [2:0] mode_nxt;
   // Settled results and their polarity-corrected form.
   logic [1:0] sync_res;
   logic [1:0] res;
   logic mismatch;
   logic [7:0] port_read;
   logic [2:0] mode;

   // Results are settled before software or the compare logic sees them,
   // since a metastable bit here could set the flag on a phantom edge.
   dcc_sync u_sync (
      .mclk(mclk),
      .rst(rst),
      .raw({cmp2_raw, cmp1_raw}),
      .sync(sync_res)
   );

   assign mode = cfg_r[dcc_pkg::MODE_MSB:0];

   // Positive above negative reads one unless the polarity bit inverts it.
   assign res[0] = sync_res[0] ^ cfg_r[dcc_pkg::INV1_BIT];
   assign res[1] = sync_res[1] ^ cfg_r[dcc_pkg::INV2_BIT];

   // Any difference from the captured pair is a pending change.
   assign mismatch = (res != cap_r);

   // Analog pins read as zero while the comparators own them.
   always_comb begin
      port_read = pin_in;
      if (mode != dcc_pkg::MODE_OFF) begin
         port_read = pin_in & ~dcc_pkg::ANALOG_MASK;
      end
   end

   // Next state of the register file, status and capture.
   always_comb begin
      cfg_nxt = cfg_r;
      port_f_direction_reg_nxt = port_f_direction_reg_r;
      port_nxt = port_r;
      mask_nxt = mask_r;
      stat_nxt = stat_r;
      cap_nxt = cap_r;
      rd_nxt = 8'h00;
      // Writes; result bits of the control word are dropped.
      if (wr_stb) begin
         if (addr == dcc_pkg::CTRL_IDX) begin
            cfg_nxt = wr_data[5:0];
         end else if (addr == dcc_pkg::DIR_IDX) begin
            port_f_direction_reg_nxt = wr_data;
         end else if (addr == dcc_pkg::PORT_IDX) begin
            port_nxt = wr_data;
         end else if (addr == dcc_pkg::MASK_IDX) begin
            mask_nxt = wr_data[dcc_pkg::CHG_BIT];
         end
      end
      // Any access to the control word takes a fresh reference pair.
      if ((wr_stb || rd_stb) && addr == dcc_pkg::CTRL_IDX) begin
         cap_nxt = res;
      end
      // Reads; unmapped addresses return zero.
      if (rd_stb) begin
         if (addr == dcc_pkg::CTRL_IDX) begin
            rd_nxt = {res[1], res[0], cfg_r};
         end else if (addr == dcc_pkg::DIR_IDX) begin
            rd_nxt = port_f_direction_reg_r;
         end else if (addr == dcc_pkg::PORT_IDX) begin
            rd_nxt = port_read;
         end else if (addr == dcc_pkg::STAT_IDX) begin
            rd_nxt = {7'h00, stat_r};
            stat_nxt = 1'h0;
         end else if (addr == dcc_pkg::MASK_IDX) begin
            rd_nxt = {7'h00, mask_r};
         end
      end
      // A change in the clearing cycle is kept: set wins.
      if (mismatch) begin
         stat_nxt = 1'h1;
      end
      // Derived analog controls follow the control word as it will stand next
      // cycle, so they switch on the same edge as the mode bits themselves.
      mode_nxt = cfg_nxt[dcc_pkg::MODE_MSB:0];
      // Both comparators run in every configuration but the off one.
      cmp_on_nxt = (mode_nxt != dcc_pkg::MODE_OFF);
      // The reference reaches the positive inputs only in the mux mode.
      ref_nxt = (mode_nxt == dcc_pkg::MODE_MUX4);
      // The switch bit matters only in the mux mode.
      negsel_nxt = (mode_nxt == dcc_pkg::MODE_MUX4) && cfg_nxt[dcc_pkg::CIS_BIT];
      // Drive enables are kept in a flop of their own so that the pad
      // enables come straight from a register, not through an inverter.
      oe_nxt = ~port_f_direction_reg_nxt;
      // The interrupt is a level of the unmasked status.
      irq_nxt = |(stat_nxt & mask_nxt);
   end

   // Register everything; reset turns the comparators off.
   always_ff @(posedge mclk) begin
      if (rst) begin
         cfg_r <= dcc_pkg::CFG_RST;
         port_f_direction_reg_r <= dcc_pkg::DIR_RST;
         port_r <= dcc_pkg::PORT_RST;
         stat_r <= dcc_pkg::STAT_RST;
         mask_r <= dcc_pkg::MASK_RST;
         cap_r <= 2'h0;
         rd_r <= 8'h00;
         cmp_on_r <= 1'b0;
         ref_r <= 1'b0;
         negsel_r <= 1'b0;
         irq_r <= 1'b0;
         oe_r <= ~dcc_pkg::DIR_RST;
      end else begin
         cfg_r <= cfg_nxt;
         port_f_direction_reg_r <= port_f_direction_reg_nxt;
         port_r <= port_nxt;
         stat_r <= stat_nxt;
         mask_r <= mask_nxt;
         cap_r <= cap_nxt;
         rd_r <= rd_nxt;
         cmp_on_r <= cmp_on_nxt;
         ref_r <= ref_nxt;
         negsel_r <= negsel_nxt;
         irq_r <= irq_nxt;
         oe_r <= oe_nxt;
      end
   end

   // Result pins take the raw, unsettled comparator level; this path is
   // deliberately combinational so the pin tracks the analog edge.
   always_comb begin
      pin_out = port_r;
      if (dcc_pkg::pin_routed(mode, 1'b0)) begin
         pin_out[dcc_pkg::PIN_RES1] = cmp1_raw ^ cfg_r[dcc_pkg::INV1_BIT];
      end
      if (dcc_pkg::pin_routed(mode, 1'b1)) begin
         pin_out[dcc_pkg::PIN_RES2] = cmp2_raw ^ cfg_r[dcc_pkg::INV2_BIT];
      end
   end

   // Direction bits gate the drivers in every mode, result pins included.
   assign pin_oe = oe_r;

   assign rd_data = rd_r;
   assign comparator_config_field = mode;
   assign cmp_on = cmp_on_r;
   assign ref_to_pos = ref_r;
   assign neg_pair_sel = negsel_r;
   assign irq = irq_r;

   // Checks on the behaviour above.
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   reset_mode_a: assert property ($past(rst) |-> mode == dcc_pkg::MODE_OFF && !cmp_on_r)
      else $error("Mode not off after reset.");

   cfg_write_a: assert property (
      wr_stb && addr == dcc_pkg::CTRL_IDX |=> cfg_r == $past(wr_data[5:0]))
      else $error("Control write not stored.");

   result_read_a: assert property (
      rd_stb && addr == dcc_pkg::CTRL_IDX |=> rd_r[7:6] == $past(res))
      else $error("Result bits wrong on read.");

   polarity_res_a: assert property (
      !$past(rst) && !$past(rst, 2) |->
      res[0] == ($past(cmp1_raw, 2) ^ cfg_r[dcc_pkg::INV1_BIT]))
      else $error("First result polarity wrong.");

   ref_pos_a: assert property (
      ##1 ref_r == (mode == dcc_pkg::MODE_MUX4))
      else $error("Reference routing wrong.");

   pin_route_a: assert property (
      mode == dcc_pkg::MODE_OUT_BOTH |->
      pin_out[dcc_pkg::PIN_RES2] == (cmp2_raw ^ cfg_r[dcc_pkg::INV2_BIT]))
      else $error("Result pin not routed.");

   pin_gate_a: assert property (
      wr_stb && addr == dcc_pkg::DIR_IDX |=> pin_oe == ~$past(wr_data))
      else $error("Direction not gating drivers.");

   analog_read_a: assert property (
      rd_stb && addr == dcc_pkg::PORT_IDX && mode != dcc_pkg::MODE_OFF
      |=> (rd_r & dcc_pkg::ANALOG_MASK) == 8'h00)
      else $error("Analog pin read nonzero.");

   flag_set_a: assert property (mismatch |=> stat_r[0] ##0 irq_r == mask_r[0])
      else $error("Change flag not set.");

   capture_a: assert property (
      rd_stb && addr == dcc_pkg::CTRL_IDX |=> cap_r == $past(res))
      else $error("Results not captured on access.");

   // Checks on derived controls, status, pins, reset and the synchroniser.
   // The comparator enable follows a control write on the next edge.
   cmp_on_a: assert property (
      wr_stb && addr == dcc_pkg::CTRL_IDX
      |=> cmp_on_r == ($past(wr_data[dcc_pkg::MODE_MSB:0]) != dcc_pkg::MODE_OFF))
      else $error("Comparator enable wrong after write.");

   // The pair select follows the switch bit only in the mux mode.
   neg_pair_a: assert property (
      wr_stb && addr == dcc_pkg::CTRL_IDX |=> negsel_r ==
      ($past(wr_data[dcc_pkg::MODE_MSB:0]) == dcc_pkg::MODE_MUX4 &&
      $past(wr_data[dcc_pkg::CIS_BIT])))
      else $error("Pair select wrong after write.");

   // A status read with no change pending clears the flag.
   stat_clear_a: assert property (
      rd_stb && addr == dcc_pkg::STAT_IDX && !mismatch |=> !stat_r[dcc_pkg::CHG_BIT])
      else $error("Change flag not cleared by read.");

   // The flag is sticky: only a status read can lower it.
   stat_hold_a: assert property (
      stat_r[dcc_pkg::CHG_BIT] && !(rd_stb && addr == dcc_pkg::STAT_IDX)
      |=> stat_r[dcc_pkg::CHG_BIT])
      else $error("Change flag lost without a read.");

   // The interrupt is high exactly while an unmasked status bit is set.
   irq_level_a: assert property (
      irq_r == (stat_r[dcc_pkg::CHG_BIT] && mask_r[dcc_pkg::CHG_BIT]))
      else $error("Interrupt level wrong.");

   // Reset leaves every pin undriven, no read data and no interrupt.
   reset_pins_a: assert property (
      $past(rst) |-> pin_oe == ~dcc_pkg::DIR_RST && rd_data == 8'h00 && !irq_r)
      else $error("Outputs not at rest after reset.");

   // Results reach the compare logic two edges after the raw level.
   sync_delay_a: assert property (
      !$past(rst) && !$past(rst, 2) |-> sync_res == $past({cmp2_raw, cmp1_raw}, 2))
      else $error("Synchroniser delay wrong.");

   // In the both-output mode the first result reaches its pin too.
   pin_first_a: assert property (
      mode == dcc_pkg::MODE_OUT_BOTH |->
      pin_out[dcc_pkg::PIN_RES1] == (cmp1_raw ^ cfg_r[dcc_pkg::INV1_BIT]))
      else $error("First result pin wrong.");

   // In the single-output mode only the second result reaches its pin.
   pin_one_a: assert property (
      mode == dcc_pkg::MODE_OUT_ONE |->
      pin_out[dcc_pkg::PIN_RES1] == port_r[dcc_pkg::PIN_RES1] &&
      pin_out[dcc_pkg::PIN_RES2] == (cmp2_raw ^ cfg_r[dcc_pkg::INV2_BIT]))
      else $error("Single output routing wrong.");

   // Outside the output modes every pin shows the port latch.
   pin_latch_a: assert property (
      mode != dcc_pkg::MODE_OUT_BOTH && mode != dcc_pkg::MODE_OUT_ONE |-> pin_out == port_r)
      else $error("Pin not from latch.");

   // With the comparators off the port reads the pins unmasked.
   port_off_a: assert property (
      rd_stb && addr == dcc_pkg::PORT_IDX && mode == dcc_pkg::MODE_OFF
      |=> rd_r == $past(pin_in))
      else $error("Port read masked while off.");

   // Read data stand only in the cycle after a read strobe.
   rd_idle_a: assert property (
      !rd_stb |=> rd_r == 8'h00)
      else $error("Read data outside read cycle.");
endmodule

// >>> verification/dcc_analog_model.sv
// Purpose: Behavioural model of the two analog comparator cores.
// Assumes: Levels are unsigned codes that stand in for voltages.
// Notes: Equal levels give a low output, standing in for the uncertain band.
`timescale 1ns/1ps
module dcc_analog_model (
   // Configuration from the block.
   input wire logic cmp_on,
   input wire logic ref_to_pos,
   // Analog levels as codes.
   input wire logic [7:0] pos1,
   input wire logic [7:0] neg1,
   input wire logic [7:0] pos2,
   input wire logic [7:0] neg2,
   input wire logic [7:0] ref_lvl,
   // Raw outputs, not tied to any clock.
   output logic cmp1_raw,
   output logic cmp2_raw
);
   // The reference replaces both positive inputs when routed; cores that are off read low.
   assign cmp1_raw = cmp_on & ((ref_to_pos ? ref_lvl : pos1) > neg1);
   assign cmp2_raw = cmp_on & ((ref_to_pos ? ref_lvl : pos2) > neg2);
endmodule

// >>> verification/tb_dcc_top.sv
// Purpose: Self-checking bench for the dual comparator control block.
// Assumes: Registers are reached one strobe at a time with a gap cycle.
// Notes: Comparator outputs come from the analog model, driven by level codes.
`timescale 1ns/1ps
module tb_dcc_top;
   // Clock, reset and register port.
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic [2:0] addr = 3'h0;
   logic [7:0] wr_data = 8'h00;
   logic wr_stb = 1'b0;
   logic rd_stb = 1'b0;
   logic [7:0] rd_data, pin_out, pin_oe, rv;
   logic [7:0] pin_in = 8'hff;
   logic [2:0] cfg;
   logic cmp1_raw, cmp2_raw, cmp_on, ref_to_pos, neg_pair_sel, irq;
   // Analog level codes for the model.
   logic [7:0] pos1 = 8'h00, neg1 = 8'h00, pos2 = 8'h00, neg2 = 8'h00, ref_lvl = 8'h00;
   int failures = 0;
   int tests_run = 0;

   // Free-running 20 MHz clock.
   always #25 mclk = ~mclk;

   dcc_top dcc_top_i (.mclk(mclk), .rst(rst), .addr(addr), .wr_data(wr_data),
      .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data), .cmp1_raw(cmp1_raw),
      .cmp2_raw(cmp2_raw), .comparator_config_field(cfg), .cmp_on(cmp_on),
      .ref_to_pos(ref_to_pos), .neg_pair_sel(neg_pair_sel), .pin_in(pin_in),
      .pin_out(pin_out), .pin_oe(pin_oe), .irq(irq));
   dcc_analog_model dcc_analog_model_i (.cmp_on(cmp_on), .ref_to_pos(ref_to_pos),
      .pos1(pos1), .neg1(neg1), .pos2(pos2), .neg2(neg2), .ref_lvl(ref_lvl),
      .cmp1_raw(cmp1_raw), .cmp2_raw(cmp2_raw));

   // One-cycle write strobe.
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge mclk);
      addr <= a;
      wr_data <= d;
      wr_stb <= 1'b1;
      @(posedge mclk);
      wr_stb <= 1'b0;
   endtask

   // One-cycle read strobe; data stand only in the following cycle.
   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge mclk);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge mclk);
      rd_stb <= 1'b0;
      #1 d = rd_data;
   endtask

   // Byte comparison.
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      tests_run++;
      if (g !== e) begin
         failures++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask

   // Single-bit comparison.
   task automatic chk1(input string n, input logic e, input logic g);
      tests_run++;
      if (g !== e) begin
         failures++;
         $display("wrong value %s expected %b seen %b", n, e, g);
      end
   endtask

   // Read a register and compare it.
   task automatic rdchk(input logic [2:0] a, input logic [7:0] e, input string n);
      rd(a, rv);
      chk(n, e, rv);
   endtask

   // Counts, then the verdict, then the end of the run.
   task automatic finish_test();
      $display("checks %0d failures %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // Watchdog: the sequence needs about 120 cycles, so this margin means a hang.
   initial begin
      repeat (3000) @(posedge mclk);
      failures++;
      finish_test();
   end

   // Main sequence.
   initial begin
      repeat (20) @(posedge mclk);
      rst <= 1'b0;
      rdchk(dcc_pkg::CTRL_IDX, 8'h07, "ctrl");
      chk("oe", 8'h00, pin_oe);
      chk1("on", 1'b0, cmp_on);
      rdchk(3'h5, 8'h00, "unmapped");
      $display("test reset done");
      // Every mode, switch bit set: only mode 110 routes the reference and the pair.
      for (int m = 0; m < 8; m++) begin
         wr(dcc_pkg::CTRL_IDX, {5'h01, 3'(m)});
         #1;
         chk("mode", {5'h00, 3'(m)}, {5'h00, cfg});
         chk1("on", m != 7, cmp_on);
         chk1("ref", m == 6, ref_to_pos);
         chk1("pair", m == 6, neg_pair_sel);
      end
      wr(dcc_pkg::CTRL_IDX, 8'h06);
      #1 chk1("pair", 1'b0, neg_pair_sel);
      $display("test modes done");
      // Reference above one negative input, below the other.
      ref_lvl <= 8'h80;
      neg1 <= 8'h40;
      neg2 <= 8'hc0;
      repeat (4) @(posedge mclk);
      rdchk(dcc_pkg::CTRL_IDX, 8'h46, "res");
      wr(dcc_pkg::CTRL_IDX, 8'hf6);
      repeat (4) @(posedge mclk);
      rdchk(dcc_pkg::CTRL_IDX, 8'hb6, "inv");
      $display("test results done");
      // Output mode with pin 1 inverted; only pins 1 and 2 driven.
      pos1 <= 8'h10;
      neg1 <= 8'h20;
      pos2 <= 8'h30;
      neg2 <= 8'h20;
      wr(dcc_pkg::CTRL_IDX, 8'h13);
      wr(dcc_pkg::PORT_IDX, 8'ha5);
      wr(dcc_pkg::DIR_IDX, 8'hf9);
      #1 chk("oe", 8'h06, pin_oe);
      chk("pins", 8'h06, pin_out & 8'h06);
      chk("latch", 8'ha1, pin_out & 8'hf9);
      rdchk(dcc_pkg::DIR_IDX, 8'hf9, "dir");
      @(posedge mclk);
      pos2 <= 8'h00;
      #1 chk1("pin2", 1'b0, pin_out[2]);
      rdchk(dcc_pkg::PORT_IDX, 8'h87, "port");
      // Single-output mode: pin 1 falls back to the latch, pin 2 inverted.
      wr(dcc_pkg::CTRL_IDX, 8'h35);
      #1 chk("pins", 8'h04, pin_out & 8'h06);
      wr(dcc_pkg::CTRL_IDX, 8'h07);
      #1 chk("latch", 8'ha5, pin_out);
      rdchk(dcc_pkg::PORT_IDX, 8'hff, "port");
      $display("test pins done");
      // Change event: mode change with the interrupt masked, then a real edge.
      wr(dcc_pkg::CTRL_IDX, 8'h06);
      repeat (4) @(posedge mclk);
      rd(dcc_pkg::CTRL_IDX, rv);
      rd(dcc_pkg::STAT_IDX, rv);
      wr(dcc_pkg::MASK_IDX, 8'h01);
      rdchk(dcc_pkg::MASK_IDX, 8'h01, "mask");
      repeat (4) @(posedge mclk);
      #1 chk1("irq", 1'b0, irq);
      neg1 <= 8'hff;
      repeat (6) @(posedge mclk);
      #1 chk1("irq", 1'b1, irq);
      rdchk(dcc_pkg::STAT_IDX, 8'h01, "stat");
      rdchk(dcc_pkg::STAT_IDX, 8'h01, "stat");
      rdchk(dcc_pkg::CTRL_IDX, 8'h86, "ctrl");
      rdchk(dcc_pkg::STAT_IDX, 8'h01, "stat");
      rdchk(dcc_pkg::STAT_IDX, 8'h00, "stat");
      repeat (2) @(posedge mclk);
      #1 chk1("irq", 1'b0, irq);
      wr(dcc_pkg::MASK_IDX, 8'h00);
      neg1 <= 8'h40;
      repeat (6) @(posedge mclk);
      #1 chk1("irq", 1'b0, irq);
      rdchk(dcc_pkg::STAT_IDX, 8'h01, "stat");
      $display("test events done");
      finish_test();
   end
endmodule
